// ---- common/tsc_defs.vh ----
`ifndef TSC_DEFS_VH
`define TSC_DEFS_VH

// Register word indices; the byte address is four times the index.
`define TSC_IDX_MODE       3'h0
`define TSC_IDX_PAIR       3'h1
`define TSC_IDX_STATUS     3'h2
`define TSC_IDX_SHAPE      3'h3

// Interface mode register fields.
`define TSC_MODE_RATE_SEL  0
`define TSC_MODE_CFG_LSB   1
`define TSC_MODE_IN_RATE   3
`define TSC_MODE_OUT_RATE  5
`define TSC_MODE_CLK_RATIO 7

// Stream pair select register fields.
`define TSC_PAIR_A_LSB     0
`define TSC_PAIR_B_LSB     4

// Reset values.
`define TSC_MODE_RESET     8'h00
`define TSC_PAIR_RESET     8'h32

// Rate field codes.
`define TSC_RATE_2M        2'h0
`define TSC_RATE_4M        2'h1
`define TSC_RATE_8M        2'h2

// Switch configuration codes at the 2.048 Mb/s identical rate.
`define TSC_CFG_8X8        2'h0
`define TSC_CFG_16X8       2'h1
`define TSC_CFG_PAIR       2'h2
`define TSC_CFG_NIBBLE     2'h3

// Active arrangement codes shown in the status register.
`define TSC_ARR_8X8        4'h0
`define TSC_ARR_16X8       4'h1
`define TSC_ARR_PAIR       4'h2
`define TSC_ARR_NIBBLE     4'h3
`define TSC_ARR_8X4        4'h4
`define TSC_ARR_4X4        4'h5
`define TSC_ARR_2X2        4'h6
`define TSC_ARR_DIFF       4'h7
`define TSC_ARR_NONE       4'hF

// Channels per frame for each rate.
`define TSC_CH_2M          8'h20
`define TSC_CH_4M          8'h40
`define TSC_CH_8M          8'h80
`define TSC_CH_NIBBLE      8'h40

// Matrix sizes.
`define TSC_MAT_128        10'h080
`define TSC_MAT_256        10'h100
`define TSC_MAT_512        10'h200

`endif

// ---- verilog/tsc_avs.v ----
module tsc_avs #(
  parameter DW = 32
) (
  input  wire          clock,
  input  wire          rst,
  input  wire          avs_read,
  input  wire          avs_write,
  input  wire [DW-1:0] rd_mux,
  output wire          avs_waitrequest,
  output wire          accept,
  output wire [DW-1:0] avs_readdata
);

  reg          ack_q;
  reg [DW-1:0] rdata_q;

  // Every access is stretched to two cycles so read data can come from a flop.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign accept          = (avs_read | avs_write) & ack_q;
  assign avs_readdata    = rdata_q;

  always @(posedge clock) begin
    if (rst) begin
      ack_q   <= 1'b0;
      rdata_q <= {DW{1'b0}};
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      if (avs_read & ~ack_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

endmodule

// ---- verilog/tsc_top.v ----
// The address map and register access over Avalon-MM were chosen for this implementation.
`include "tsc_defs.vh"

// Contract
// - Identical rates: arrangement chosen by the switch configuration bits at 2.048 and 4.096 Mb/s.
// - Different rates: always non-blocking, stream counts from the two rate fields.
// - Identical rates: both rates from input rate field, output field ignored.
// - At 2.048 Mb/s: 8x8, 16x8, stream-pair or nibble arrangements.
// - 8x8: eight by eight streams of 32 channels, 256x256 non-blocking, delay choice.
// - 16x8: 512x256 blocking, variable delay only, multiplexed bus mode only.
// - Stream-pair: pairs 0,1 fixed plus pairs A,B from 2..9, 128x128.
// - Stream-pair: 4.096 MHz clock, per-channel variable or constant delay.
// - Nibble: 64 nibbles per stream, eight in by four out, 512x256 blocking.
// - 4.096 Mb/s 8x4: 512x256 blocking, 64 channels, variable delay only.
// - 4.096 Mb/s 4x4: 256x256 non-blocking with delay choice.
// - 8.192 Mb/s: two by two streams of 128 slots, configuration bits ignored.
// - Different rates: input and output rates from their fields, configuration bits ignored.
// - Different rates: counts from rates, 256x256 non-blocking with delay choice.
// - One common rate for all inputs, one for all outputs.
module tsc_top (
  input  wire        clock,
  input  wire        rst,
  input  wire [2:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [3:0]  avs_byteenable,
  input  wire [31:0] avs_writedata,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        frame_pulse_input,
  input  wire        mux_bus_mode,
  output wire [3:0]  active_arrangement,
  output wire [1:0]  active_input_rate,
  output wire [1:0]  active_output_rate,
  output wire [15:0] input_stream_enable,
  output wire [9:0]  serial_output_stream_oe_n,
  output wire [7:0]  input_channels,
  output wire [7:0]  output_channels,
  output wire [9:0]  matrix_inputs,
  output wire [9:0]  matrix_outputs,
  output wire        blocking_matrix,
  output wire        const_delay_allowed,
  output wire        nibble_mode,
  output wire        config_error,
  output wire        config_pending
);

  function [15:0] low_mask;
    input [4:0] n;
    begin
      low_mask = (16'h0001 << n) - 16'h0001;
    end
  endfunction
  function [15:0] pair_bit;
    input [3:0] p;
    begin
      pair_bit = (p >= 4'h2 && p <= 4'h9) ? (16'h0001 << p) : 16'h0000;
    end
  endfunction
  function [7:0] rate_chans;
    input [1:0] r;
    begin
      case (r)
        `TSC_RATE_2M: rate_chans = `TSC_CH_2M;
        `TSC_RATE_4M: rate_chans = `TSC_CH_4M;
        `TSC_RATE_8M: rate_chans = `TSC_CH_8M;
        default:      rate_chans = 8'h00;
      endcase
    end
  endfunction

  reg  [7:0]  mode_q;
  reg  [7:0]  pair_q;
  reg         frame_q;
  reg         pending_q;
  reg  [3:0]  arr_q;
  reg  [1:0]  irate_q;
  reg  [1:0]  orate_q;
  reg  [15:0] in_en_q;
  reg  [9:0]  out_oe_n_q;
  reg  [7:0]  in_ch_q;
  reg  [7:0]  out_ch_q;
  reg  [9:0]  mat_in_q;
  reg  [9:0]  mat_out_q;
  reg         blk_q;
  reg         cd_q;
  reg         nib_q;
  reg         err_q;
  reg         rate_sel_act_q;
  reg  [3:0]  d_arr;
  reg  [1:0]  d_irate;
  reg  [1:0]  d_orate;
  reg  [4:0]  d_in_n;
  reg  [4:0]  d_out_n;
  reg  [15:0] d_pair;
  reg         d_use_pair;
  reg  [15:0] d_in_mask;
  reg  [15:0] d_out_mask;
  reg  [9:0]  d_mi;
  reg  [9:0]  d_mo;
  reg         d_blk;
  reg         d_cd;
  reg         d_nib;
  reg         d_err;
  reg  [31:0] rd_mux;
  wire        rate_sel  = mode_q[`TSC_MODE_RATE_SEL];
  wire [1:0]  cfg_bits  = mode_q[`TSC_MODE_CFG_LSB +: 2];
  wire [1:0]  in_rate   = mode_q[`TSC_MODE_IN_RATE +: 2];
  wire [1:0]  out_rate  = mode_q[`TSC_MODE_OUT_RATE +: 2];
  wire        clk_ratio = mode_q[`TSC_MODE_CLK_RATIO];
  wire [3:0]  pa        = pair_q[`TSC_PAIR_A_LSB +: 4];
  wire [3:0]  pb        = pair_q[`TSC_PAIR_B_LSB +: 4];
  wire        accept;
  wire        boundary = frame_pulse_input & ~frame_q;
  wire        wr_ok    = accept & avs_write & avs_byteenable[0];
  wire        wr_mode  = wr_ok & (avs_address == `TSC_IDX_MODE);
  wire        wr_pair  = wr_ok & (avs_address == `TSC_IDX_PAIR);
  wire        clk_mismatch = ~rate_sel_act_q & (clk_ratio != (irate_q != `TSC_RATE_2M));

  tsc_avs #(
    .DW (32)
  ) u_avs (
    .clock           (clock),
    .rst             (rst),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .rd_mux          (rd_mux),
    .avs_waitrequest (avs_waitrequest),
    .accept          (accept),
    .avs_readdata    (avs_readdata)
  );

  // Decode of the programmed mode into the next frame's arrangement.
  always @* begin
    d_arr      = `TSC_ARR_NONE;
    d_irate    = in_rate;
    d_orate    = in_rate;
    d_in_n     = 5'h00;
    d_out_n    = 5'h00;
    d_pair     = 16'h0000;
    d_use_pair = 1'b0;
    d_mi       = 10'h000;
    d_mo       = 10'h000;
    d_blk      = 1'b0;
    d_cd       = 1'b0;
    d_nib      = 1'b0;
    d_err      = 1'b0;
    if (!rate_sel) begin
      case (in_rate)
        `TSC_RATE_2M: begin
          case (cfg_bits)
            `TSC_CFG_16X8: begin
              if (mux_bus_mode) begin
                d_arr   = `TSC_ARR_16X8;
                d_in_n  = 5'h10;
                d_out_n = 5'h08;
                d_blk   = 1'b1;
                d_mi    = `TSC_MAT_512;
                d_mo    = `TSC_MAT_256;
              end else begin
                d_err   = 1'b1;
                d_arr   = `TSC_ARR_8X8;
                d_in_n  = 5'h08;
                d_out_n = 5'h08;
                d_cd    = 1'b1;
                d_mi    = `TSC_MAT_256;
                d_mo    = `TSC_MAT_256;
              end
            end
            `TSC_CFG_PAIR: begin
              d_arr      = `TSC_ARR_PAIR;
              d_use_pair = 1'b1;
              d_pair     = 16'h0003 | pair_bit(pa) | pair_bit(pb);
              d_err      = (pair_bit(pa) == 16'h0000) | (pair_bit(pb) == 16'h0000) | (pa == pb);
              d_cd       = 1'b1;
              d_mi       = `TSC_MAT_128;
              d_mo       = `TSC_MAT_128;
            end
            `TSC_CFG_NIBBLE: begin
              d_arr   = `TSC_ARR_NIBBLE;
              d_in_n  = 5'h08;
              d_out_n = 5'h04;
              d_nib   = 1'b1;
              d_blk   = 1'b1;
              d_mi    = `TSC_MAT_512;
              d_mo    = `TSC_MAT_256;
            end
            default: begin
              d_arr   = `TSC_ARR_8X8;
              d_in_n  = 5'h08;
              d_out_n = 5'h08;
              d_cd    = 1'b1;
              d_mi    = `TSC_MAT_256;
              d_mo    = `TSC_MAT_256;
            end
          endcase
        end
        `TSC_RATE_4M: begin
          if (cfg_bits[0]) begin
            d_arr   = `TSC_ARR_4X4;
            d_in_n  = 5'h04;
            d_out_n = 5'h04;
            d_cd    = 1'b1;
            d_mi    = `TSC_MAT_256;
            d_mo    = `TSC_MAT_256;
          end else begin
            d_arr   = `TSC_ARR_8X4;
            d_in_n  = 5'h08;
            d_out_n = 5'h04;
            d_blk   = 1'b1;
            d_mi    = `TSC_MAT_512;
            d_mo    = `TSC_MAT_256;
          end
        end
        `TSC_RATE_8M: begin
          d_arr   = `TSC_ARR_2X2;
          d_in_n  = 5'h02;
          d_out_n = 5'h02;
          d_cd    = 1'b1;
          d_mi    = `TSC_MAT_256;
          d_mo    = `TSC_MAT_256;
        end
        default: begin
          d_err = 1'b1;
        end
      endcase
    end else begin
      d_orate = out_rate;
      d_arr   = `TSC_ARR_DIFF;
      d_cd    = 1'b1;
      d_mi    = `TSC_MAT_256;
      d_mo    = `TSC_MAT_256;
      case ({in_rate, out_rate})
        {`TSC_RATE_2M, `TSC_RATE_4M}: begin
          d_in_n  = 5'h08;
          d_out_n = 5'h04;
        end
        {`TSC_RATE_2M, `TSC_RATE_8M}: begin
          d_in_n  = 5'h08;
          d_out_n = 5'h02;
        end
        {`TSC_RATE_4M, `TSC_RATE_2M}: begin
          d_in_n  = 5'h04;
          d_out_n = 5'h08;
        end
        {`TSC_RATE_8M, `TSC_RATE_2M}: begin
          d_in_n  = 5'h02;
          d_out_n = 5'h08;
        end
        default: begin
          d_err = 1'b1;
          d_arr = `TSC_ARR_NONE;
          d_cd  = 1'b0;
          d_mi  = 10'h000;
          d_mo  = 10'h000;
        end
      endcase
    end
    d_in_mask  = d_use_pair ? d_pair : low_mask(d_in_n);
    d_out_mask = d_use_pair ? d_pair : low_mask(d_out_n);
  end

  always @* begin
    case (avs_address)
      `TSC_IDX_MODE:   rd_mux = {24'h000000, mode_q};
      `TSC_IDX_PAIR:   rd_mux = {24'h000000, pair_q};
      `TSC_IDX_STATUS: rd_mux = {17'h00000, orate_q, irate_q, rate_sel_act_q, clk_mismatch, pending_q,
                                 err_q, nib_q, cd_q, blk_q, arr_q};
      `TSC_IDX_SHAPE:  rd_mux = {out_ch_q, in_ch_q, mat_out_q[9:2], mat_in_q[9:2]};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      mode_q     <= `TSC_MODE_RESET;
      pair_q     <= `TSC_PAIR_RESET;
      frame_q    <= 1'b0;
      pending_q  <= 1'b1;
      arr_q      <= `TSC_ARR_NONE;
      irate_q    <= `TSC_RATE_2M;
      orate_q    <= `TSC_RATE_2M;
      in_en_q    <= 16'h0000;
      out_oe_n_q <= 10'h3FF;
      in_ch_q    <= 8'h00;
      out_ch_q   <= 8'h00;
      mat_in_q   <= 10'h000;
      mat_out_q  <= 10'h000;
      blk_q      <= 1'b0;
      cd_q       <= 1'b0;
      nib_q      <= 1'b0;
      err_q      <= 1'b0;
      rate_sel_act_q <= 1'b0;
    end else begin
      frame_q <= frame_pulse_input;
      if (wr_mode) mode_q <= avs_writedata[7:0];
      if (wr_pair) pair_q <= avs_writedata[7:0];
      // A write in the boundary cycle was not yet decoded, so it stays pending.
      pending_q <= wr_mode | wr_pair | (pending_q & ~boundary);
      if (boundary) begin
        arr_q      <= d_arr;
        irate_q    <= d_irate;
        orate_q    <= d_orate;
        in_en_q    <= d_in_mask;
        out_oe_n_q <= ~d_out_mask[9:0];
        in_ch_q    <= d_nib ? `TSC_CH_NIBBLE : rate_chans(d_irate);
        out_ch_q   <= d_nib ? `TSC_CH_NIBBLE : rate_chans(d_orate);
        mat_in_q   <= d_mi;
        mat_out_q  <= d_mo;
        blk_q      <= d_blk;
        cd_q       <= d_cd;
        nib_q      <= d_nib;
        err_q      <= d_err;
        rate_sel_act_q <= rate_sel;
      end
    end
  end

  assign active_arrangement        = arr_q;
  assign active_input_rate         = irate_q;
  assign active_output_rate        = orate_q;
  assign input_stream_enable       = in_en_q;
  assign serial_output_stream_oe_n = out_oe_n_q;
  assign input_channels            = in_ch_q;
  assign output_channels           = out_ch_q;
  assign matrix_inputs             = mat_in_q;
  assign matrix_outputs            = mat_out_q;
  assign blocking_matrix           = blk_q;
  assign const_delay_allowed       = cd_q;
  assign nibble_mode               = nib_q;
  assign config_error              = err_q;
  assign config_pending            = pending_q;

endmodule

// ---- tb/tsc_frame_src.sv ----
module tsc_frame_src (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic [3:0] dly,
  output logic            frame_pulse_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_q;

  // One frame pulse, two cycles wide, per request after dly idle cycles; low between frames.
  always @(posedge clock) begin
    if (rst) cnt_q <= 5'h00;
    else if (go) cnt_q <= {1'b0, dly} + 5'h02;
    else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
  end
  assign frame_pulse_input = (cnt_q == 5'h01) || (cnt_q == 5'h02);
endmodule

// ---- tb/tsc_top_asserts.sv ----
module tsc_chk (
  input wire        clock,
  input wire        rst,
  input wire [2:0]  avs_address,
  input wire        avs_write,
  input wire [3:0]  avs_byteenable,
  input wire        avs_waitrequest,
  input wire        frame_pulse_input,
  input wire        mux_bus_mode,
  input wire [3:0]  active_arrangement,
  input wire [1:0]  active_input_rate,
  input wire [1:0]  active_output_rate,
  input wire [7:0]  output_channels,
  input wire        config_error,
  input wire [15:0] input_stream_enable,
  input wire [9:0]  serial_output_stream_oe_n,
  input wire [7:0]  input_channels,
  input wire [9:0]  matrix_inputs,
  input wire [9:0]  matrix_outputs,
  input wire        blocking_matrix,
  input wire        const_delay_allowed,
  input wire        nibble_mode,
  input wire        config_pending
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic fp_q;
  always @(posedge clock) fp_q <= rst ? 1'b0 : frame_pulse_input;
  wire bnd  = frame_pulse_input && !fp_q;
  wire wacc = avs_write && !avs_waitrequest && avs_byteenable[0] && (avs_address < 3'h2);
  sequence s_wr; wacc; endsequence
  sequence s_edge; bnd && !wacc; endsequence
  wire [3:0] arr = active_arrangement;
  wire [9:0] oen = serial_output_stream_oe_n;

  AST_HOLD: assert property (!bnd |=> $stable(arr) && $stable(oen) && $stable(input_stream_enable))
    else $error("configuration changed inside a frame");
  AST_PEND_SET: assert property (s_wr |=> config_pending)
    else $error("pending not set by register write");
  AST_PEND_CLR: assert property (s_edge |=> !config_pending)
    else $error("pending not cleared at frame boundary");
  AST_8X8: assert property (arr == 4'h0 |-> oen == 10'h300 && input_channels == 8'h20 && const_delay_allowed)
    else $error("8x8 shape wrong");
  AST_16X8: assert property (arr == 4'h1 |-> blocking_matrix && !const_delay_allowed && matrix_inputs == 10'h200)
    else $error("16x8 shape wrong");
  AST_MUX: assert property (bnd && !mux_bus_mode |=> arr != 4'h1)
    else $error("16x8 without multiplexed bus");
  AST_PAIR: assert property (arr == 4'h2 |-> input_stream_enable[1:0] == 2'h3 && matrix_inputs == 10'h080)
    else $error("pair mode shape wrong");
  AST_NIB: assert property (arr == 4'h3 |-> nibble_mode && blocking_matrix && oen == 10'h3F0)
    else $error("nibble shape wrong");
  AST_8X4: assert property (arr == 4'h4 |-> blocking_matrix && !const_delay_allowed && input_channels == 8'h40)
    else $error("8x4 shape wrong");
  AST_4X4: assert property (arr == 4'h5 |-> !blocking_matrix && input_stream_enable == 16'h000F)
    else $error("4x4 shape wrong");
  AST_2X2: assert property (arr == 4'h6 |-> input_channels == 8'h80 && oen == 10'h3FC)
    else $error("2x2 shape wrong");
  AST_DIFF: assert property (arr == 4'h7 |-> !blocking_matrix && matrix_outputs == 10'h100)
    else $error("different-rate matrix wrong");
  AST_NONE: assert property (arr == 4'hF |-> oen == 10'h3FF)
    else $error("outputs driven with no arrangement");
  AST_RATE: assert property (arr != 4'h7 && arr != 4'hF |-> active_output_rate == active_input_rate)
    else $error("identical-rate output rate differs from input rate");
  AST_NIBCH: assert property (arr == 4'h3 |-> input_channels == 8'h40 && output_channels == 8'h40)
    else $error("nibble channel count wrong");
  AST_ERR16: assert property (arr == 4'h1 |-> !config_error)
    else $error("16x8 active with error flag");
endmodule

bind tsc_top tsc_chk u_tsc_chk (.clock, .rst, .avs_address, .avs_write, .avs_byteenable, .avs_waitrequest,
  .frame_pulse_input, .mux_bus_mode, .active_arrangement, .active_input_rate, .active_output_rate,
  .output_channels, .config_error, .input_stream_enable, .serial_output_stream_oe_n,
  .input_channels, .matrix_inputs, .matrix_outputs, .blocking_matrix, .const_delay_allowed, .nibble_mode,
  .config_pending);

// ---- tb/tsc_top_tb.sv ----
module tsc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst, avs_read, avs_write, go, mux_bus_mode;
  logic [2:0]  avs_address;
  logic [3:0]  avs_byteenable, dly;
  logic [31:0] avs_writedata, rv;
  wire         avs_waitrequest, config_pending, frame_pulse_input;
  wire [31:0]  avs_readdata;
  wire [15:0]  input_stream_enable;
  wire [9:0]   serial_output_stream_oe_n;
  logic [57:0] q[$];
  logic [14:0] ps;
  logic [15:0] pi;
  logic [9:0]  po;
  integer      seed, mismatches, total_checks, cyc;

  tsc_top u_tsc_top (.clock, .rst, .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .frame_pulse_input, .mux_bus_mode, .active_arrangement(),
    .active_input_rate(), .active_output_rate(), .input_stream_enable, .serial_output_stream_oe_n,
    .input_channels(), .output_channels(), .matrix_inputs(), .matrix_outputs(), .blocking_matrix(),
    .const_delay_allowed(), .nibble_mode(), .config_error(), .config_pending);
  tsc_frame_src u_tsc_frame_src (.clock, .rst, .go, .dly, .frame_pulse_input);

  always #20 clock = ~clock;

  task final_report;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [57:0] s, input logic [57:0] e);
    total_checks = total_checks + 1;
    if (s !== e) begin
      mismatches = mismatches + 1;
      $display("[ERR] read oe_n/enables/data expected %h seen %h", e, s);
    end
  endtask

  // Each read note carries the stream controls expected alongside the data.
  always @(posedge clock) if (avs_read && !avs_waitrequest) chk({serial_output_stream_oe_n, input_stream_enable,
    avs_readdata}, q.pop_front());

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      mismatches = mismatches + 1;
      final_report;
    end
  end

  task bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h000000, d};
    do @(posedge clock); while (avs_waitrequest);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task rd(input logic [2:0] a, input logic [31:0] d);
    q.push_back({po, pi, d});
    bus(1'b0, a, 8'h00);
  endtask

  task cfg(input logic [7:0] m, input logic [14:0] st, input logic [31:0] sh, input logic [15:0] e,
           input logic [9:0] o);
    integer n;
    bus(1'b1, 3'h0, m);
    // The clock-ratio check compares the new ratio bit with the rate still active.
    rd(3'h2, {17'h00000, ps | 15'h0100 | {5'h00, ~ps[10] & (m[7] != (ps[12:11] != 2'h0)), 9'h000}});
    rv = $random(seed);
    dly <= rv[3:0];
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    n = 0;
    while (config_pending && n < 60) begin
      @(posedge clock);
      n = n + 1;
    end
    ps = st;
    pi = e;
    po = o;
    rd(3'h2, {17'h00000, st});
    rd(3'h3, sh);
    rd(3'h0, {24'h000000, m});
  endtask

  task dr(input logic [1:0] i, input logic [1:0] o, input logic [7:0] ic, input logic [7:0] oc,
          input logic [15:0] e, input logic [9:0] n);
    rv = $random(seed);
    cfg(8'h01 | {1'b0, o, i, 3'h0} | (rv[7:0] & 8'h86), {o, i, 11'h427}, {oc, ic, 16'h4040}, e, n);
  endtask

  initial begin
    clock = 0;
    rst = 1;
    avs_address = 0;
    avs_read = 0;
    avs_write = 0;
    avs_byteenable = 4'hF;
    avs_writedata = 0;
    go = 0;
    dly = 0;
    mux_bus_mode = 1;
    seed = 23;
    mismatches = 0;
    total_checks = 0;
    cyc = 0;
    ps = 15'h000F;
    pi = 16'h0000;
    po = 10'h3FF;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(3'h1, 32'h00000032);
    rd(3'h5, 32'h00000000);
    avs_byteenable <= 4'hE;
    bus(1'b1, 3'h0, 8'hFF);
    avs_byteenable <= 4'hF;
    rd(3'h0, 32'h00000000);
    cfg(8'h00, 15'h0020, 32'h20204040, 16'h00FF, 10'h300);
    cfg(8'h02, 15'h0011, 32'h20204080, 16'hFFFF, 10'h300);
    mux_bus_mode <= 1'b0;
    cfg(8'h02, 15'h00A0, 32'h20204040, 16'h00FF, 10'h300);
    mux_bus_mode <= 1'b1;
    cfg(8'h04, 15'h0022, 32'h20202020, 16'h000F, 10'h3F0);
    bus(1'b1, 3'h1, 8'h95);
    rd(3'h1, 32'h00000095);
    cfg(8'h04, 15'h0022, 32'h20202020, 16'h0223, 10'h1DC);
    cfg(8'h06, 15'h0053, 32'h40404080, 16'h00FF, 10'h3F0);
    cfg(8'h88, 15'h2814, 32'h40404080, 16'h00FF, 10'h3F0);
    cfg(8'h8A, 15'h2825, 32'h40404040, 16'h000F, 10'h3F0);
    rv = $random(seed);
    cfg(8'h90 | (rv[7:0] & 8'h66), 15'h5026, 32'h80804040, 16'h0003, 10'h3FC);
    dr(2'h0, 2'h1, 8'h20, 8'h40, 16'h00FF, 10'h3F0);
    dr(2'h0, 2'h2, 8'h20, 8'h80, 16'h00FF, 10'h3FC);
    dr(2'h1, 2'h0, 8'h40, 8'h20, 16'h000F, 10'h300);
    dr(2'h2, 2'h0, 8'h80, 8'h20, 16'h0003, 10'h300);
    cfg(8'h29, 15'h2C8F, 32'h40400000, 16'h0000, 10'h3FF);
    repeat (2) @(posedge clock);
    final_report;
  end
endmodule
